// file: src/dfpt_pkg.sv
// Constants, register map and types for the serial pass-through router
`default_nettype none
package dfpt_pkg;
    // Clock and millisecond tick
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_REQ_TO = 8'h04;
    localparam logic [7:0] ADDR_BUSY_TO = 8'h08;
    localparam logic [7:0] ADDR_ACK_TO = 8'h0C;
    localparam logic [7:0] ADDR_RETRY = 8'h10;
    localparam logic [7:0] ADDR_MIN_DLY = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_INT_STAT = 8'h1C;
    localparam logic [7:0] ADDR_INT_EN = 8'h20;
    localparam logic [7:0] ADDR_INT_CLR = 8'h24;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PT_BIT = 1;
    localparam int CTRL_HALF_BIT = 2;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_TRIES_LSB = 8;
    // Reset values and limits
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [15:0] RST_REQ_TO = 16'h03E8;
    localparam logic [15:0] RST_BUSY_TO = 16'h01F4;
    localparam logic [15:0] RST_ACK_TO = 16'h0064;
    localparam logic [15:0] REQ_TO_MAX = 16'h2710;
    localparam logic [3:0] RST_RETRY = 4'h3;
    localparam logic [3:0] RETRY_MAX = 4'hA;
    localparam logic [15:0] RST_MIN_DLY = 16'h000A;
    // Link characters
    localparam logic [7:0] CH_DLE = 8'h10;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_SOH = 8'h01;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [1:0] TRAIL_BYTES = 2'h2;
    // Interrupt event bits
    localparam int EV_DONE = 0;
    localparam int EV_REQ_TO = 1;
    localparam int EV_BUSY_TO = 2;
    localparam int EV_ACK_TO = 3;
    localparam int EV_FAIL = 4;
    localparam int EV_OVF = 5;
    localparam int EV_W = 6;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_WAIT_FREE,
        ST_GAP,
        ST_SEND,
        ST_WAIT_RSP,
        ST_WAIT_ACK
    } dfpt_state_e;
endpackage
`default_nettype wire

// file: src/dfpt_ms_timer.sv
// Millisecond down-counting timeout timer
`default_nettype none
module dfpt_ms_timer #(
    parameter int W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic cancel,
    input wire logic tick,
    input wire logic [W-1:0] load,
    output logic running,
    output logic expired
);
    logic [W-1:0] cnt_reg;
    logic run_reg;

    initial
    begin
        if (W < 1) $error("dfpt_ms_timer: W must be at least 1");
    end

    assign running = run_reg;
    assign expired = run_reg && (cnt_reg == '0);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg <= load;
            run_reg <= 1'b1;
        end
        else if (cancel || expired)
            run_reg <= 1'b0;
        else if (tick)
            cnt_reg <= cnt_reg - W'(1);
    end
endmodule
`default_nettype wire

// file: src/dfpt_router.sv
// Serial pass-through router with AHB-Lite register slave
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none
// Functional notes
// - Pass-through runs only while the enable bit is set.
// - Debug port either relays to port zero or serves plain debug traffic.
// - Request timer starts on DLE-STX, or DLE-SOH in half-duplex mode.
// - Request timer expiry discards the partial request.
// - Busy flag stands while the master port runs a command-list transaction.
// - Busy timeout expiry while port busy aborts the held message.
// - Port freed before busy timeout: forward the held request.
// - After a response, wait up to the ack timeout for DLE-ACK.
// - Timeout defaults 1000, 500, 100 ms, each programmable.
// - Failed command retried up to the retry count, default three.
// - Minimum delay precedes each new command but not retries.
module dfpt_router
    import dfpt_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES,
    parameter int BUF_DEPTH = 256
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic host_rx_valid,
    input wire logic [7:0] host_rx_data,
    output logic host_tx_valid,
    output logic [7:0] host_tx_data,
    output logic dbg_rx_valid,
    output logic [7:0] dbg_rx_data,
    input wire logic dbg_tx_valid,
    input wire logic [7:0] dbg_tx_data,
    input wire logic mport_cmd_active,
    output logic mport_tx_valid,
    output logic [7:0] mport_tx_data,
    input wire logic mport_tx_ready,
    input wire logic mport_rsp_valid,
    input wire logic [7:0] mport_rsp_data,
    input wire logic mport_rsp_last,
    input wire logic mport_fail,
    output logic pt_busy,
    output logic irq
);
    localparam int AW = $clog2(BUF_DEPTH);
    localparam int PW = AW + 1;
    localparam int IW = AW + 2;
    localparam int TW = $clog2(MS_TICK_CYCLES + 1);

    initial
    begin
        if (BUF_DEPTH < 4) $error("dfpt_router: BUF_DEPTH below 4");
        if (MS_TICK_CYCLES < 1) $error("dfpt_router: MS_TICK_CYCLES below 1");
    end

    dfpt_state_e state_reg, state_next;
    logic [2:0] ctrl_reg;
    logic [15:0] req_to_reg, busy_to_reg, ack_to_reg, min_dly_reg;
    logic [3:0] retry_reg, tries_reg;
    logic [EV_W-1:0] int_stat_reg, int_en_reg, ev;
    logic [31:0] hrdata_reg;
    logic ap_valid_reg, ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic [TW-1:0] pre_reg;
    logic tick_reg;
    logic [7:0] mem [BUF_DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [IW-1:0] idx_reg;
    logic dle_reg, trail_reg;
    logic [1:0] trail_cnt_reg;
    logic host_tx_valid_reg, dbg_rx_valid_reg, tx_valid_reg, busy_reg, irq_reg;
    logic [7:0] host_tx_data_reg, dbg_rx_data_reg, tx_data_reg;
    logic req_start, busy_start, gap_start, ack_start;
    logic req_run, busy_run, gap_run, ack_run;
    logic req_exp, busy_exp, gap_exp, ack_exp;

    // Bus decode
    wire ap_take = hsel && htrans[1] && hready;
    wire wr_en = ap_valid_reg && ap_write_reg;
    wire [7:0] ra = haddr[7:0];
    wire [31:0] stat_word = {20'h0, tries_reg, 3'h0, busy_reg, 1'b0, state_reg};
    wire [31:0] rd_mux =
        (ra == ADDR_CTRL) ? {29'h0, ctrl_reg} :
        (ra == ADDR_REQ_TO) ? {16'h0, req_to_reg} :
        (ra == ADDR_BUSY_TO) ? {16'h0, busy_to_reg} :
        (ra == ADDR_ACK_TO) ? {16'h0, ack_to_reg} :
        (ra == ADDR_RETRY) ? {28'h0, retry_reg} :
        (ra == ADDR_MIN_DLY) ? {16'h0, min_dly_reg} :
        (ra == ADDR_STATUS) ? stat_word :
        (ra == ADDR_INT_STAT) ? {26'h0, int_stat_reg} :
        (ra == ADDR_INT_EN) ? {26'h0, int_en_reg} : 32'h0;
    wire [15:0] wd16 = hwdata[15:0];
    wire [EV_W-1:0] clr_mask = (wr_en && ap_addr_reg == ADDR_INT_CLR) ? hwdata[EV_W-1:0] : '0;
    wire [EV_W-1:0] int_stat_next = (int_stat_reg & ~clr_mask) | ev;

    // Link decode
    wire pt_active = ctrl_reg[CTRL_EN_BIT] && ctrl_reg[CTRL_PT_BIT];
    wire rx_byte = host_rx_valid && pt_active;
    wire [7:0] open_ch = ctrl_reg[CTRL_HALF_BIT] ? CH_SOH : CH_STX;
    wire start_hit = state_reg == ST_IDLE && rx_byte && dle_reg && host_rx_data == open_ch;
    wire etx_hit = rx_byte && dle_reg && host_rx_data == CH_ETX && !trail_reg;
    wire msg_end = rx_byte && trail_reg && trail_cnt_reg == 2'h1;
    wire buf_full = wr_ptr_reg == PW'(BUF_DEPTH);
    wire ack_hit = state_reg == ST_WAIT_ACK && rx_byte && dle_reg && host_rx_data == CH_ACK;
    wire can_load = !tx_valid_reg || mport_tx_ready;
    wire more = idx_reg < ({1'b0, wr_ptr_reg} + IW'(2));
    wire [IW-1:0] idx_m2 = idx_reg - IW'(2);
    wire [7:0] send_byte = (idx_reg == '0) ? CH_DLE : (idx_reg == IW'(1)) ? CH_STX :
                           mem[idx_m2[AW-1:0]];
    wire send_done = state_reg == ST_SEND && can_load && !more;
    wire do_retry = state_reg == ST_WAIT_RSP && mport_fail && tries_reg < retry_reg;

    always_comb
    begin
        state_next = state_reg;
        ev = '0;
        req_start = 1'b0;
        busy_start = 1'b0;
        gap_start = 1'b0;
        ack_start = 1'b0;
        unique case (state_reg)
            ST_IDLE:
                if (start_hit)
                begin
                    state_next = ST_RECV;
                    req_start = 1'b1;
                end
            ST_RECV:
                if (req_exp)
                begin
                    state_next = ST_IDLE;
                    ev[EV_REQ_TO] = 1'b1;
                end
                else if (rx_byte && buf_full)
                begin
                    state_next = ST_IDLE;
                    ev[EV_OVF] = 1'b1;
                end
                else if (msg_end)
                begin
                    state_next = ST_WAIT_FREE;
                    busy_start = 1'b1;
                end
            ST_WAIT_FREE:
                if (busy_exp)
                begin
                    state_next = ST_IDLE;
                    ev[EV_BUSY_TO] = 1'b1;
                end
                else if (!mport_cmd_active)
                begin
                    state_next = ST_GAP;
                    gap_start = 1'b1;
                end
            ST_GAP:
                if (gap_exp)
                    state_next = ST_SEND;
            ST_SEND:
                if (send_done)
                    state_next = ST_WAIT_RSP;
            ST_WAIT_RSP:
                if (mport_fail)
                begin
                    state_next = do_retry ? ST_SEND : ST_IDLE;
                    ev[EV_FAIL] = !do_retry;
                end
                else if (mport_rsp_valid && mport_rsp_last)
                begin
                    state_next = ST_WAIT_ACK;
                    ack_start = 1'b1;
                end
            ST_WAIT_ACK:
                if (ack_hit)
                begin
                    state_next = ST_IDLE;
                    ev[EV_DONE] = 1'b1;
                end
                else if (ack_exp)
                begin
                    state_next = ST_IDLE;
                    ev[EV_ACK_TO] = 1'b1;
                end
        endcase
        if (!pt_active)
            state_next = ST_IDLE;
    end

    dfpt_ms_timer #(.W(16)) u_req_tmr (.hclk(hclk), .hresetn(hresetn), .start(req_start),
        .cancel(state_reg != ST_RECV), .tick(tick_reg), .load(req_to_reg),
        .running(req_run), .expired(req_exp));
    dfpt_ms_timer #(.W(16)) u_busy_tmr (.hclk(hclk), .hresetn(hresetn), .start(busy_start),
        .cancel(state_reg != ST_WAIT_FREE), .tick(tick_reg), .load(busy_to_reg),
        .running(busy_run), .expired(busy_exp));
    dfpt_ms_timer #(.W(16)) u_gap_tmr (.hclk(hclk), .hresetn(hresetn), .start(gap_start),
        .cancel(state_reg != ST_GAP), .tick(tick_reg), .load(min_dly_reg),
        .running(gap_run), .expired(gap_exp));
    dfpt_ms_timer #(.W(16)) u_ack_tmr (.hclk(hclk), .hresetn(hresetn), .start(ack_start),
        .cancel(state_reg != ST_WAIT_ACK), .tick(tick_reg), .load(ack_to_reg),
        .running(ack_run), .expired(ack_exp));

    // Millisecond tick
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= pre_reg == TW'(MS_TICK_CYCLES - 1);
            pre_reg <= (pre_reg == TW'(MS_TICK_CYCLES - 1)) ? '0 : pre_reg + TW'(1);
        end
    end

    // Bus slave and registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0;
            ctrl_reg <= RST_CTRL;
            req_to_reg <= RST_REQ_TO;
            busy_to_reg <= RST_BUSY_TO;
            ack_to_reg <= RST_ACK_TO;
            retry_reg <= RST_RETRY;
            min_dly_reg <= RST_MIN_DLY;
            int_en_reg <= '0;
            int_stat_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            ap_valid_reg <= ap_take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= ra;
            hrdata_reg <= (ap_take && !hwrite) ? rd_mux : 32'h0;
            if (wr_en && ap_addr_reg == ADDR_CTRL) ctrl_reg <= hwdata[2:0];
            if (wr_en && ap_addr_reg == ADDR_REQ_TO)
                req_to_reg <= (wd16 > REQ_TO_MAX) ? REQ_TO_MAX : wd16;
            if (wr_en && ap_addr_reg == ADDR_BUSY_TO) busy_to_reg <= wd16;
            if (wr_en && ap_addr_reg == ADDR_ACK_TO) ack_to_reg <= wd16;
            if (wr_en && ap_addr_reg == ADDR_RETRY)
                retry_reg <= (hwdata[3:0] > RETRY_MAX) ? RETRY_MAX : hwdata[3:0];
            if (wr_en && ap_addr_reg == ADDR_MIN_DLY) min_dly_reg <= wd16;
            if (wr_en && ap_addr_reg == ADDR_INT_EN) int_en_reg <= hwdata[EV_W-1:0];
            int_stat_reg <= int_stat_next;
            irq_reg <= |(int_stat_reg & int_en_reg);
        end
    end

    // Receive parsing and holding buffer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= ST_IDLE;
            dle_reg <= 1'b0;
            trail_reg <= 1'b0;
            trail_cnt_reg <= 2'h0;
            wr_ptr_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (rx_byte)
                dle_reg <= host_rx_data == CH_DLE && !dle_reg && !start_hit;
            if (start_hit)
            begin
                wr_ptr_reg <= '0;
                trail_reg <= 1'b0;
            end
            else if (state_reg == ST_RECV && rx_byte && !buf_full)
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            if (etx_hit)
            begin
                trail_reg <= 1'b1;
                trail_cnt_reg <= TRAIL_BYTES;
            end
            else if (rx_byte && trail_reg)
                trail_cnt_reg <= trail_cnt_reg - 2'h1;
        end
    end

    always_ff @(posedge hclk)
    begin
        if (state_reg == ST_RECV && rx_byte && !buf_full)
            mem[wr_ptr_reg[AW-1:0]] <= host_rx_data;
    end

    // Forwarding, retries and output paths
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            idx_reg <= '0;
            tries_reg <= 4'h0;
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 8'h00;
        end
        else
        begin
            if (state_reg == ST_GAP)
                tries_reg <= 4'h0;
            else if (do_retry)
                tries_reg <= tries_reg + 4'h1;
            if (state_reg != ST_SEND)
                idx_reg <= '0;
            else if (can_load && more)
                idx_reg <= idx_reg + IW'(1);
            if (can_load)
            begin
                tx_valid_reg <= state_reg == ST_SEND && more;
                tx_data_reg <= send_byte;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            host_tx_valid_reg <= 1'b0;
            host_tx_data_reg <= 8'h00;
            dbg_rx_valid_reg <= 1'b0;
            dbg_rx_data_reg <= 8'h00;
            busy_reg <= 1'b0;
        end
        else
        begin
            dbg_rx_valid_reg <= host_rx_valid && !pt_active;
            dbg_rx_data_reg <= host_rx_data;
            host_tx_valid_reg <= pt_active ? (state_reg == ST_WAIT_RSP && mport_rsp_valid) :
                                 dbg_tx_valid;
            host_tx_data_reg <= pt_active ? mport_rsp_data : dbg_tx_data;
            busy_reg <= mport_cmd_active;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign host_tx_valid = host_tx_valid_reg;
    assign host_tx_data = host_tx_data_reg;
    assign dbg_rx_valid = dbg_rx_valid_reg;
    assign dbg_rx_data = dbg_rx_data_reg;
    assign mport_tx_valid = tx_valid_reg;
    assign mport_tx_data = tx_data_reg;
    assign pt_busy = busy_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_frame_open;
        state_reg == ST_IDLE ##0 start_hit;
    endsequence
    sequence s_ack_lost;
        state_reg == ST_WAIT_ACK ##0 (ack_exp && !ack_hit && pt_active);
    endsequence

    a_disable_idle: assert property (!pt_active |=> state_reg == ST_IDLE)
        else $error("path not idle while disabled");
    a_debug_relay: assert property (host_rx_valid && !pt_active |=>
        dbg_rx_valid && !host_tx_valid || dbg_rx_valid)
        else $error("debug byte not relayed");
    a_req_timer_go: assert property (s_frame_open |=> req_run && state_reg == ST_RECV)
        else $error("request timer not started");
    a_req_abort: assert property (state_reg == ST_RECV && req_exp |=>
        state_reg == ST_IDLE && int_stat_reg[EV_REQ_TO])
        else $error("expired request not discarded");
    a_busy_flag: assert property ($rose(mport_cmd_active) |=> pt_busy)
        else $error("busy flag not raised");
    a_busy_abort: assert property (state_reg == ST_WAIT_FREE && busy_exp && pt_active |=>
        state_reg == ST_IDLE ##1 int_stat_reg[EV_BUSY_TO])
        else $error("busy timeout did not abort");
    a_forward_req: assert property (state_reg == ST_WAIT_FREE && !busy_exp && !mport_cmd_active
        && pt_active |=> state_reg == ST_GAP && gap_run)
        else $error("free port not used");
    a_ack_wait: assert property (state_reg == ST_WAIT_RSP && mport_rsp_valid && mport_rsp_last
        && !mport_fail && pt_active |=> ack_run && state_reg == ST_WAIT_ACK)
        else $error("ack wait not started");
    a_retry_limit: assert property (state_reg == ST_WAIT_RSP && mport_fail && pt_active &&
        tries_reg >= retry_reg |=> state_reg == ST_IDLE)
        else $error("retry beyond count");
    a_retry_no_gap: assert property (do_retry && pt_active |=>
        state_reg == ST_SEND ##1 mport_tx_valid && mport_tx_data == CH_DLE)
        else $error("retry delayed");
    a_ack_expire: assert property (s_ack_lost |=> state_reg == ST_IDLE ##1
        int_stat_reg[EV_ACK_TO])
        else $error("ack expiry not handled");
endmodule
`default_nettype wire

// file: tb/dfpt_mport_model.sv
// Behavioural model of the master serial port behind the router
`default_nettype none
module dfpt_mport_model
    import dfpt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fail_all,
    input wire logic mport_tx_valid,
    input wire logic [7:0] mport_tx_data,
    output logic mport_tx_ready,
    output logic mport_rsp_valid,
    output logic [7:0] mport_rsp_data,
    output logic mport_rsp_last,
    output logic mport_fail,
    output logic [15:0] rx_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] prev_reg;
    logic [1:0] trail_reg;
    logic [1:0] phase_reg;
    logic in_trail_reg;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mport_tx_ready <= 1'b0;
            mport_rsp_valid <= 1'b0;
            mport_rsp_data <= 8'h00;
            mport_rsp_last <= 1'b0;
            mport_fail <= 1'b0;
            rx_count <= 16'h0;
            prev_reg <= 8'h00;
            trail_reg <= 2'h0;
            phase_reg <= 2'h0;
            in_trail_reg <= 1'b0;
        end
        else
        begin
            // Full-duplex master, ready only every other cycle
            mport_tx_ready <= ~mport_tx_ready;
            mport_rsp_valid <= 1'b0;
            mport_rsp_last <= 1'b0;
            mport_fail <= 1'b0;
            mport_rsp_data <= ~mport_rsp_data;
            if (mport_tx_valid && mport_tx_ready)
            begin
                rx_count <= rx_count + 16'h1;
                prev_reg <= mport_tx_data;
                if (in_trail_reg)
                    trail_reg <= trail_reg + 2'h1;
                if (prev_reg == CH_DLE && mport_tx_data == CH_ETX)
                    in_trail_reg <= 1'b1;
                if (in_trail_reg && trail_reg == 2'h1)
                begin
                    in_trail_reg <= 1'b0;
                    trail_reg <= 2'h0;
                    phase_reg <= 2'h1;
                end
            end
            else if (phase_reg != 2'h0)
            begin
                // Enabled command answered once per attempt
                mport_fail <= fail_all && phase_reg == 2'h1;
                mport_rsp_valid <= ~fail_all;
                mport_rsp_data <= (phase_reg == 2'h1) ? 8'h55 : 8'h66;
                mport_rsp_last <= ~fail_all && phase_reg == 2'h2;
                phase_reg <= (fail_all || phase_reg == 2'h2) ? 2'h0 : 2'h2;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_dfpt_router.sv
// Self-checking bench for the serial pass-through router
`default_nettype none
module tb_dfpt_router
    import dfpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, host_rx_valid = 1'b0, host_tx_valid, dbg_rx_valid;
    logic [7:0] host_rx_data = 8'h00, host_tx_data, dbg_rx_data, mport_tx_data, rsp_d, htx_last;
    logic mport_cmd_active = 1'b0, mport_tx_valid, tx_rdy, rsp_v, rsp_l, mfail;
    logic fail_all = 1'b0, pt_busy, irq, dbg_tx_valid = 1'b0;
    logic [7:0] dbg_tx_data = 8'h00, dbg_last;
    logic [31:0] mtx_hist = '0;
    logic [15:0] rx_count;
    int fail_count = 0, tests_run = 0, cyc = 0, htx_n = 0, dbg_n = 0;
    dfpt_router #(.MS_TICK_CYCLES(20)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .host_rx_valid, .host_rx_data, .host_tx_valid, .host_tx_data, .dbg_rx_valid,
        .dbg_rx_data, .dbg_tx_valid, .dbg_tx_data, .mport_cmd_active,
        .mport_tx_valid, .mport_tx_data, .mport_tx_ready(tx_rdy), .mport_rsp_valid(rsp_v),
        .mport_rsp_data(rsp_d), .mport_rsp_last(rsp_l), .mport_fail(mfail), .pt_busy, .irq);
    dfpt_mport_model PEER (.hclk, .hresetn, .fail_all, .mport_tx_valid, .mport_tx_data,
        .mport_tx_ready(tx_rdy), .mport_rsp_valid(rsp_v), .mport_rsp_data(rsp_d),
        .mport_rsp_last(rsp_l), .mport_fail(mfail), .rx_count);
    initial forever #25 hclk = ~hclk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (host_tx_valid === 1'b1)
        begin
            htx_n++;
            htx_last = host_tx_data;
        end
        if (dbg_rx_valid === 1'b1)
        begin
            dbg_n++;
            dbg_last = dbg_rx_data;
        end
        if (mport_tx_valid === 1'b1 && tx_rdy === 1'b1)
            mtx_hist = {mtx_hist[23:0], mport_tx_data};
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic tx(input logic [7:0] b);
        host_rx_valid <= 1'b1;
        host_rx_data <= b;
        @(posedge hclk);
        host_rx_valid <= 1'b0;
        host_rx_data <= ~b;
        @(posedge hclk);
    endtask
    task automatic frame(input int n);
        logic [7:0] f [7] = '{CH_DLE, CH_STX, 8'hAA, CH_DLE, CH_ETX, 8'hC1, 8'hC2};
        for (int i = 0; i < n; i++) tx(f[i]);
    endtask
    task automatic wait_st(input logic [2:0] s);
        q = 32'h7;
        for (int i = 0; i < 400 && q[2:0] !== s; i++) ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("state", {29'h0, s}, {29'h0, q[2:0]});
        q = 32'h0;
    endtask
    task automatic int_is(input logic [31:0] exp);
        ahb(1'b0, ADDR_INT_STAT, 32'h0);
        chk("int_stat", exp, q);
        ahb(1'b1, ADDR_INT_CLR, 32'h3F);
    endtask
    task automatic t_regs();
        logic [7:0] a [4] = '{ADDR_REQ_TO, ADDR_BUSY_TO, ADDR_ACK_TO, ADDR_RETRY};
        logic [31:0] v [4] = '{32'h3E8, 32'h1F4, 32'h64, 32'h3};
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b0, a[i], 32'h0);
            chk("reset value", v[i], q);
        end
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("hresp", 32'h0, hresp);
        ahb(1'b1, ADDR_REQ_TO, 32'hFFFF);
        ahb(1'b0, ADDR_REQ_TO, 32'h0);
        chk("req_to clamp", 32'h2710, q);
        $display("test regs done");
    endtask
    task automatic t_debug();
        for (int m = 0; m < 2; m++)
        begin
            ahb(1'b1, ADDR_CTRL, m);
            dbg_n = 0;
            frame(7);
            @(posedge hclk);
            chk("dbg bytes", 32'd7, dbg_n);
            chk("dbg data", 32'hC2, dbg_last);
            dbg_tx_valid <= 1'b1;
            dbg_tx_data <= 8'h5A ^ 8'(m);
            @(posedge hclk);
            dbg_tx_valid <= 1'b0;
            repeat (2) @(posedge hclk);
            chk("dbg echo", 32'h5A ^ m, htx_last);
            wait_st(ST_IDLE);
        end
        $display("test debug done");
    endtask
    task automatic t_full();
        logic [15:0] n0;
        n0 = rx_count;
        {htx_n, dbg_n} = 0;
        ahb(1'b1, ADDR_INT_EN, 32'h3F);
        ahb(1'b1, ADDR_MIN_DLY, 32'h1);
        ahb(1'b1, ADDR_CTRL, 32'h3);
        mport_cmd_active <= 1'b1;
        frame(7);
        wait_st(ST_WAIT_FREE);
        chk("pt_busy", 32'h1, pt_busy);
        chk("held", 32'h0, rx_count - n0);
        mport_cmd_active <= 1'b0;
        wait_st(ST_WAIT_ACK);
        chk("forwarded", 32'd7, rx_count - n0);
        chk("fwd tail", 32'h1003C1C2, mtx_hist);
        chk("echo count", 32'd2, htx_n);
        chk("echo data", 32'h66, htx_last);
        chk("dbg quiet", 32'h0, dbg_n);
        tx(CH_DLE);
        tx(CH_ACK);
        wait_st(ST_IDLE);
        chk("irq set", 32'h1, irq);
        int_is(32'h1);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("irq clear", 32'h0, irq);
        $display("test full done");
    endtask
    task automatic t_faults();
        logic [15:0] n0;
        ahb(1'b1, ADDR_REQ_TO, 32'h2);
        frame(3);
        wait_st(ST_IDLE);
        int_is(32'h2);
        ahb(1'b1, ADDR_REQ_TO, 32'h3E8);
        ahb(1'b1, ADDR_BUSY_TO, 32'h2);
        mport_cmd_active <= 1'b1;
        frame(7);
        wait_st(ST_IDLE);
        int_is(32'h4);
        mport_cmd_active <= 1'b0;
        ahb(1'b1, ADDR_ACK_TO, 32'h2);
        frame(7);
        wait_st(ST_WAIT_ACK);
        wait_st(ST_IDLE);
        int_is(32'h8);
        fail_all <= 1'b1;
        n0 = rx_count;
        frame(7);
        wait_st(ST_IDLE);
        int_is(32'h10);
        chk("attempts", 32'd28, rx_count - n0);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("tries", 32'h3, {28'h0, q[11:8]});
        fail_all <= 1'b0;
        $display("test faults done");
    endtask
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_debug();
        t_full();
        t_faults();
        close_out();
    end
endmodule
`default_nettype wire
